// [src/pm_cmd_pkg.sv]
/*
 constants, register map, defaults and carrier types of the power manager command bank.
 assumes one 50 MHz clock with a synchronous active-high reset.
*/
// Function
// [RQ1] switch in continuous conduction at fixed frequency, never skipping cycles
// [RQ2] ramp low-side on-time over the first 128 switching cycles after start
// [RQ3] after 128 cycles the low-side switch is the full high-side complement
// [RQ4] pin-only control uses the on/off pin and ignores the run command
// [RQ5] on/off pin polarity comes from the on/off configuration
// [RQ6] command-only control uses the run command and ignores the pin
// [RQ7] combined control regulates only while pin and run command both ask on
// [RQ8] on/off configuration at 02h resets to 16h and is storable
// [RQ9] fault clear at 03h zeroes fault status and releases the alert line
// [RQ10] write guard at 10h gates writes; default 00h allows all
// [RQ11] save command at 11h copies storable settings into nonvolatile memory
// [RQ12] reload command at 12h copies stored settings back into operation
// [RQ13] feature report at 19h is read-only and returns b0h
// [RQ14] alert mask at 1bh keeps status bits off alert; power-good-low masked
// [RQ15] output format report at 20h is read-only and returns 17h
// [RQ16] upper clamp at 24h limits setpoint; reset 034dh or 069ah by scale
// [RQ17] lower clamp at 2bh limits setpoint; reset 00b3h or 0166h by scale
// [RQ18] slew rate at 27h resets to d03ch
// [RQ19] sense divider ratio at 29h resets to f004h and is storable
// [RQ20] start conversion at start level 35h, stop below stop level 36h
// [RQ21] overcurrent fault level at 46h resets to f854h
// [RQ22] fault actions at 41h, 45h, 47h select latch, restart or ignore; the code only stores them and never acts on them
// [RQ23] non-default write guard rejects writes to every other register
package pm_cmd_pkg;

	// command codes
	localparam logic [7:0] CMD_RUN = 8'h01;
	localparam logic [7:0] CMD_ONOFF = 8'h02;
	localparam logic [7:0] CMD_FCLR = 8'h03;
	localparam logic [7:0] CMD_GUARD = 8'h10;
	localparam logic [7:0] CMD_SAVE = 8'h11;
	localparam logic [7:0] CMD_RELOAD = 8'h12;
	localparam logic [7:0] CMD_USAVE = 8'h15;
	localparam logic [7:0] CMD_URELOAD = 8'h16;
	localparam logic [7:0] CMD_FEAT = 8'h19;
	localparam logic [7:0] CMD_AMASK = 8'h1b;
	localparam logic [7:0] CMD_OFMT = 8'h20;
	localparam logic [7:0] CMD_SETPT = 8'h21;
	localparam logic [7:0] CMD_UPPER = 8'h24;
	localparam logic [7:0] CMD_SLEW = 8'h27;
	localparam logic [7:0] CMD_SCALE = 8'h29;
	localparam logic [7:0] CMD_LOWER = 8'h2b;
	localparam logic [7:0] CMD_VSTART = 8'h35;
	localparam logic [7:0] CMD_VSTOP = 8'h36;
	localparam logic [7:0] CMD_TRIM = 8'h39;
	localparam logic [7:0] CMD_OVACT = 8'h41;
	localparam logic [7:0] CMD_UVACT = 8'h45;
	localparam logic [7:0] CMD_OCLVL = 8'h46;
	localparam logic [7:0] CMD_OCACT = 8'h47;
	localparam logic [7:0] CMD_OCWARN = 8'h4a;
	localparam logic [7:0] CMD_STATUS = 8'h78;

	// reset values
	localparam logic [7:0] RST_RUN = 8'h00;
	localparam logic [7:0] RST_ONOFF = 8'h16;
	localparam logic [7:0] RST_GUARD = 8'h00;
	localparam logic [7:0] FEAT_VAL = 8'hb0;
	localparam logic [7:0] RST_AMASK = 8'h08;
	localparam logic [7:0] OFMT_VAL = 8'h17;
	localparam logic [15:0] RST_SETPT = 16'h0133;
	localparam logic [15:0] UPPER_S1 = 16'h034d;
	localparam logic [15:0] UPPER_S05 = 16'h069a;
	localparam logic [15:0] LOWER_S1 = 16'h00b3;
	localparam logic [15:0] LOWER_S05 = 16'h0166;
	localparam logic [15:0] LOWER_S025 = 16'h02cc;
	localparam logic [15:0] RST_SLEW = 16'hd03c;
	localparam logic [15:0] SCALE_1 = 16'hf004;
	localparam logic [15:0] SCALE_05 = 16'hf002;
	localparam logic [15:0] SCALE_025 = 16'hf001;
	localparam logic [15:0] RST_VSTART = 16'hf012;
	localparam logic [15:0] RST_VSTOP = 16'hf010;
	localparam logic [15:0] RST_TRIM = 16'he000;
	localparam logic [7:0] RST_OVACT = 8'hbf;
	localparam logic [7:0] RST_UVACT = 8'hbf;
	localparam logic [15:0] RST_OCLVL = 16'hf854;
	localparam logic [7:0] RST_OCACT = 8'hff;
	localparam logic [15:0] RST_OCWARN = 16'hf84a;

	// field positions
	localparam int ONOFF_PU_BIT = 4;
	localparam int ONOFF_CMD_BIT = 3;
	localparam int ONOFF_PIN_BIT = 2;
	localparam int ONOFF_POL_BIT = 1;
	localparam int RUN_ON_BIT = 7;
	localparam int STAT_CML_BIT = 1;
	localparam int MANT_W = 11;

	// bus and switching timing
	localparam logic [6:0] DEV_ADDR = 7'h24;
	localparam int CLK_KHZ = 50000;
	localparam int SW_KHZ = 500;
	localparam int SW_PERIOD = CLK_KHZ / SW_KHZ;
	localparam int CNT_W = 7;
	localparam logic [CNT_W-1:0] SW_LAST = CNT_W'(SW_PERIOD - 1);
	localparam logic [7:0] RAMP_CYCLES = 8'd128;
	localparam int RAMP_SHIFT = 7;

	typedef struct packed {
		logic [7:0] onoff;
		logic [7:0] guard;
		logic [7:0] amask;
		logic [15:0] setpt;
		logic [15:0] scale;
		logic [15:0] vstart;
		logic [15:0] vstop;
		logic [15:0] trim;
		logic [7:0] ovact;
		logic [7:0] uvact;
		logic [15:0] oclvl;
		logic [7:0] ocact;
	} store_t;

	localparam store_t STORE_RST = '{RST_ONOFF, RST_GUARD, RST_AMASK, RST_SETPT, SCALE_1,
		RST_VSTART, RST_VSTOP, RST_TRIM, RST_OVACT, RST_UVACT, RST_OCLVL, RST_OCACT};

	typedef struct packed {
		logic valid;
		logic [7:0] cmd;
		logic [15:0] data;
	} wr_req_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_RECV = 3'b001,
		S_ACKO = 3'b011,
		S_SEND = 3'b010,
		S_ACKI = 3'b110,
		S_IGN = 3'b111
	} bus_st_t;

	// data bytes carried by a command: 0 none, 1 byte, 2 word
	function automatic logic [1:0] cmd_bytes(input logic [7:0] c);
		case (c)
			CMD_RUN, CMD_ONOFF, CMD_GUARD, CMD_FEAT, CMD_AMASK, CMD_OFMT,
			CMD_OVACT, CMD_UVACT, CMD_OCACT, CMD_STATUS: cmd_bytes = 2'd1;
			CMD_SETPT, CMD_UPPER, CMD_SLEW, CMD_SCALE, CMD_LOWER, CMD_VSTART,
			CMD_VSTOP, CMD_TRIM, CMD_OCLVL, CMD_OCWARN: cmd_bytes = 2'd2;
			default: cmd_bytes = 2'd0;
		endcase
	endfunction

endpackage

// [src/power_manager_command_bank.sv]
/*
 command register bank, two-wire command slave, enable logic and switching gates.
 assumes bus pins, on/off pin and fault events arrive from outside the clock domain
 except input_level_i and duty_i, which come from logic on clk_i.
*/
`timescale 1ns/1ps
module power_manager_command_bank
	import pm_cmd_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// command bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic alert_o,
	output logic alert_oe_o,
	// control pins and converter side
	input wire logic onoff_input_pin_i,
	input wire logic [7:0] fault_evt_i,
	input wire logic [15:0] input_level_i,
	input wire logic [CNT_W-1:0] duty_i,
	output logic regulate_o,
	output logic hs_gate_o,
	output logic ls_gate_o,
	output logic [15:0] vout_target_o
);

	logic scl_m_q, scl_s_q, scl_d_q, sda_m_q, sda_s_q, sda_d_q, pin_m_q, pin_s_q;
	logic [7:0] evt_m_q, evt_s_q;
	logic scl_rise, scl_fall, bus_start, bus_stop;
	bus_st_t st_q;
	logic [2:0] bit_q;
	logic full_q, rw_q;
	logic [7:0] sh_q, cmd_q, lo_q;
	logic [2:0] idx_q;
	logic [1:0] rd_idx_q;
	wr_req_t wr_q;
	logic exec_q;
	logic [7:0] exec_cmd_q;
	store_t cfg_q, nvm_q;
	logic [7:0] run_q, fault_q;
	logic [15:0] upper_q, lower_q, slew_q, ocwarn_q;
	logic [15:0] rd_val;
	logic wr_ok, guard_on;
	logic pin_act, en_act, vin_ok_q, reg_q;
	logic [CNT_W-1:0] cnt_q, duty_c, comp;
	logic [7:0] ramp_q;
	logic [14:0] ls_prod;
	logic [7:0] ls_allow;
	logic [CNT_W:0] ls_pos;

	// two-flop synchronisers
	always_ff @(posedge clk_i) begin
		scl_m_q <= scl_i;
		scl_s_q <= scl_m_q;
		scl_d_q <= scl_s_q;
		sda_m_q <= sda_i;
		sda_s_q <= sda_m_q;
		sda_d_q <= sda_s_q;
		pin_m_q <= onoff_input_pin_i;
		pin_s_q <= pin_m_q;
		evt_m_q <= fault_evt_i;
		evt_s_q <= evt_m_q;
	end

	assign scl_rise = scl_s_q & ~scl_d_q;
	assign scl_fall = ~scl_s_q & scl_d_q;
	assign bus_start = scl_s_q & scl_d_q & sda_d_q & ~sda_s_q;
	assign bus_stop = scl_s_q & scl_d_q & ~sda_d_q & sda_s_q;

	// bus engine
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= S_IDLE;
			bit_q <= 3'd0;
			full_q <= 1'b0;
			rw_q <= 1'b0;
			sh_q <= 8'h00;
			cmd_q <= 8'h00;
			lo_q <= 8'h00;
			idx_q <= 3'd0;
			rd_idx_q <= 2'd0;
			sda_oe_o <= 1'b0;
			wr_q <= '0;
			exec_q <= 1'b0;
			exec_cmd_q <= 8'h00;
		end else begin
			wr_q.valid <= 1'b0;
			exec_q <= 1'b0;
			if (bus_stop) begin
				if (st_q != S_IGN && idx_q == 3'd2 && !rw_q && cmd_bytes(cmd_q) == 2'd0) begin
					exec_q <= 1'b1;
					exec_cmd_q <= cmd_q;
				end
				st_q <= S_IDLE;
				sda_oe_o <= 1'b0;
			end else if (bus_start) begin
				st_q <= S_RECV;
				bit_q <= 3'd0;
				full_q <= 1'b0;
				idx_q <= 3'd0;
				sda_oe_o <= 1'b0;
			end else begin
				case (st_q)
					S_RECV: begin
						if (scl_rise && !full_q) begin
							sh_q <= {sh_q[6:0], sda_s_q};
							bit_q <= bit_q + 3'd1;
							if (bit_q == 3'd7)
								full_q <= 1'b1;
						end else if (scl_fall && full_q) begin
							full_q <= 1'b0;
							if (idx_q == 3'd0) begin
								if (sh_q[7:1] == DEV_ADDR) begin
									rw_q <= sh_q[0];
									st_q <= S_ACKO;
									sda_oe_o <= 1'b1;
								end else begin
									st_q <= S_IGN;
								end
							end else begin
								st_q <= S_ACKO;
								sda_oe_o <= 1'b1;
								if (idx_q == 3'd1)
									cmd_q <= sh_q;
								else if (idx_q == 3'd2)
									lo_q <= sh_q;
								if (idx_q == 3'd2 && cmd_bytes(cmd_q) == 2'd1)
									wr_q <= '{1'b1, cmd_q, {8'h00, sh_q}};
								if (idx_q == 3'd3 && cmd_bytes(cmd_q) == 2'd2)
									wr_q <= '{1'b1, cmd_q, {sh_q, lo_q}};
							end
							if (idx_q != 3'd7)
								idx_q <= idx_q + 3'd1;
						end
					end
					S_ACKO: begin
						if (scl_fall) begin
							bit_q <= 3'd0;
							if (rw_q && idx_q == 3'd1) begin
								st_q <= S_SEND;
								sh_q <= rd_val[7:0];
								rd_idx_q <= 2'd1;
								sda_oe_o <= ~rd_val[7];
							end else begin
								st_q <= S_RECV;
								sda_oe_o <= 1'b0;
							end
						end
					end
					S_SEND: begin
						if (scl_fall) begin
							if (bit_q == 3'd7) begin
								st_q <= S_ACKI;
								sda_oe_o <= 1'b0;
							end else begin
								sh_q <= {sh_q[6:0], 1'b0};
								bit_q <= bit_q + 3'd1;
								sda_oe_o <= ~sh_q[6];
							end
						end
					end
					S_ACKI: begin
						if (scl_rise && sda_s_q) begin
							st_q <= S_IGN;
						end else if (scl_fall) begin
							st_q <= S_SEND;
							bit_q <= 3'd0;
							if (rd_idx_q == 2'd1) begin
								sh_q <= rd_val[15:8];
								sda_oe_o <= ~rd_val[15];
								rd_idx_q <= 2'd2;
							end else begin
								sh_q <= 8'h00;
								sda_oe_o <= 1'b1;
							end
						end
					end
					S_IDLE, S_IGN: begin
						sda_oe_o <= 1'b0;
					end
					default: begin
						st_q <= S_IDLE;
						sda_oe_o <= 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		sda_o <= 1'b0;
	end

	// write acceptance
	assign guard_on = cfg_q.guard != RST_GUARD;
	// [RQ23] guard blocks writes
	assign wr_ok = !guard_on || wr_q.cmd == CMD_GUARD;

	// read multiplexer
	always_comb begin
		case (cmd_q)
			CMD_RUN: rd_val = {8'h00, run_q};
			CMD_ONOFF: rd_val = {8'h00, cfg_q.onoff};
			CMD_GUARD: rd_val = {8'h00, cfg_q.guard};
			// [RQ13] fixed feature value
			CMD_FEAT: rd_val = {8'h00, FEAT_VAL};
			CMD_AMASK: rd_val = {8'h00, cfg_q.amask};
			// [RQ15] fixed format value
			CMD_OFMT: rd_val = {8'h00, OFMT_VAL};
			CMD_SETPT: rd_val = cfg_q.setpt;
			CMD_UPPER: rd_val = upper_q;
			CMD_SLEW: rd_val = slew_q;
			CMD_SCALE: rd_val = cfg_q.scale;
			CMD_LOWER: rd_val = lower_q;
			CMD_VSTART: rd_val = cfg_q.vstart;
			CMD_VSTOP: rd_val = cfg_q.vstop;
			CMD_TRIM: rd_val = cfg_q.trim;
			CMD_OVACT: rd_val = {8'h00, cfg_q.ovact};
			CMD_UVACT: rd_val = {8'h00, cfg_q.uvact};
			CMD_OCLVL: rd_val = cfg_q.oclvl;
			CMD_OCACT: rd_val = {8'h00, cfg_q.ocact};
			CMD_OCWARN: rd_val = ocwarn_q;
			CMD_STATUS: rd_val = {8'h00, fault_q};
			default: rd_val = 16'h0000;
		endcase
	end

	// storable settings
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// [RQ8] [RQ19] storable reset values
			cfg_q <= STORE_RST;
		end else if (exec_q && !guard_on &&
			(exec_cmd_q == CMD_RELOAD || exec_cmd_q == CMD_URELOAD)) begin
			// [RQ12] reload from memory
			cfg_q <= nvm_q;
		end else if (wr_q.valid && wr_ok) begin
			case (wr_q.cmd)
				CMD_ONOFF: cfg_q.onoff <= wr_q.data[7:0];
				// [RQ10] guard register write
				CMD_GUARD: cfg_q.guard <= wr_q.data[7:0];
				// [RQ14] mask write
				CMD_AMASK: cfg_q.amask <= wr_q.data[7:0];
				CMD_SETPT: cfg_q.setpt <= wr_q.data;
				CMD_SCALE: cfg_q.scale <= wr_q.data;
				CMD_VSTART: cfg_q.vstart <= wr_q.data;
				CMD_VSTOP: cfg_q.vstop <= wr_q.data;
				CMD_TRIM: cfg_q.trim <= wr_q.data;
				// [RQ22] fault actions
				CMD_OVACT: cfg_q.ovact <= wr_q.data[7:0];
				CMD_UVACT: cfg_q.uvact <= wr_q.data[7:0];
				// [RQ21] overcurrent level
				CMD_OCLVL: cfg_q.oclvl <= wr_q.data;
				CMD_OCACT: cfg_q.ocact <= wr_q.data[7:0];
				default: cfg_q <= cfg_q;
			endcase
		end
	end

	// nonvolatile copy
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nvm_q <= STORE_RST;
		end else if (exec_q && !guard_on &&
			(exec_cmd_q == CMD_SAVE || exec_cmd_q == CMD_USAVE)) begin
			// [RQ11] save to memory
			nvm_q <= cfg_q;
		end
	end

	// volatile settings
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_q <= RST_RUN;
			// [RQ16] [RQ17] [RQ18] volatile reset values
			upper_q <= UPPER_S1;
			lower_q <= LOWER_S1;
			slew_q <= RST_SLEW;
			ocwarn_q <= RST_OCWARN;
		end else if (exec_q && !guard_on &&
			(exec_cmd_q == CMD_RELOAD || exec_cmd_q == CMD_URELOAD)) begin
			// [RQ16] [RQ17] lower clamp follows scale; upper clamp follows at scales 1 and 0.5 only and keeps its value at 0.25
			if (nvm_q.scale == SCALE_05) begin
				upper_q <= UPPER_S05;
				lower_q <= LOWER_S05;
			end else if (nvm_q.scale == SCALE_025) begin
				lower_q <= LOWER_S025;
			end else begin
				upper_q <= UPPER_S1;
				lower_q <= LOWER_S1;
			end
		end else if (wr_q.valid && wr_ok) begin
			case (wr_q.cmd)
				CMD_RUN: run_q <= wr_q.data[7:0];
				CMD_UPPER: upper_q <= wr_q.data;
				CMD_LOWER: lower_q <= wr_q.data;
				CMD_SLEW: slew_q <= wr_q.data;
				CMD_OCWARN: ocwarn_q <= wr_q.data;
				default: run_q <= run_q;
			endcase
		end
	end

	// fault status and alert
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_q <= 8'h00;
			alert_oe_o <= 1'b0;
			alert_o <= 1'b0;
		end else begin
			// [RQ9] clear, set wins
			fault_q <= ((exec_q && exec_cmd_q == CMD_FCLR) ? 8'h00 : fault_q) | evt_s_q |
				((wr_q.valid && !wr_ok) ? 8'(1 << STAT_CML_BIT) : 8'h00);
			// [RQ14] masked alert
			alert_oe_o <= |(fault_q & ~cfg_q.amask);
			alert_o <= 1'b0;
		end
	end

	// enable source selection
	// [RQ5] pin polarity
	assign pin_act = cfg_q.onoff[ONOFF_POL_BIT] ? pin_s_q : ~pin_s_q;
	always_comb begin
		case ({cfg_q.onoff[ONOFF_PU_BIT], cfg_q.onoff[ONOFF_CMD_BIT], cfg_q.onoff[ONOFF_PIN_BIT]})
			// [RQ4] pin only
			3'b101: en_act = pin_act;
			// [RQ6] command only
			3'b110: en_act = run_q[RUN_ON_BIT];
			// [RQ7] both required
			3'b111: en_act = pin_act & run_q[RUN_ON_BIT];
			3'b100: en_act = 1'b0;
			default: en_act = 1'b1;
		endcase
	end

	// input level window and regulation
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vin_ok_q <= 1'b0;
			reg_q <= 1'b0;
			regulate_o <= 1'b0;
			vout_target_o <= RST_SETPT;
		end else begin
			// [RQ20] start and stop thresholds
			if (input_level_i[MANT_W-1:0] >= cfg_q.vstart[MANT_W-1:0])
				vin_ok_q <= 1'b1;
			else if (input_level_i[MANT_W-1:0] < cfg_q.vstop[MANT_W-1:0])
				vin_ok_q <= 1'b0;
			reg_q <= vin_ok_q & en_act;
			regulate_o <= vin_ok_q & en_act;
			// [RQ16] [RQ17] setpoint clamp
			if (cfg_q.setpt > upper_q)
				vout_target_o <= upper_q;
			else if (cfg_q.setpt < lower_q)
				vout_target_o <= lower_q;
			else
				vout_target_o <= cfg_q.setpt;
		end
	end

	// switching gates
	assign duty_c = (duty_i > SW_LAST) ? SW_LAST : duty_i;
	assign comp = SW_LAST - duty_c + CNT_W'(1);
	assign ls_prod = 15'(comp) * 15'(ramp_q);
	// [RQ2] [RQ3] ramped or full complement
	assign ls_allow = (ramp_q >= RAMP_CYCLES) ? 8'(comp) : ls_prod[RAMP_SHIFT +: 8];
	assign ls_pos = {1'b0, cnt_q} - {1'b0, duty_c};

	always_ff @(posedge clk_i) begin
		if (rst_i || !reg_q) begin
			cnt_q <= '0;
			ramp_q <= 8'h00;
			hs_gate_o <= 1'b0;
			ls_gate_o <= 1'b0;
		end else begin
			// [RQ1] fixed period every cycle
			cnt_q <= (cnt_q == SW_LAST) ? '0 : cnt_q + CNT_W'(1);
			// [RQ2] count first cycles
			if (cnt_q == SW_LAST && ramp_q < RAMP_CYCLES)
				ramp_q <= ramp_q + 8'd1;
			hs_gate_o <= cnt_q < duty_c;
			ls_gate_o <= (cnt_q >= duty_c) && (8'(ls_pos) < ls_allow);
		end
	end

endmodule

// [dv/power_manager_command_bank_props.sv]
/*
 port checks of the command bank: reset state, switching period and width,
 low-side ramp and complement, open-drain outputs.
 assumes duty_i stays between 1 and 99 while regulating.
*/
`timescale 1ns/1ps
module power_manager_command_bank_props
	import pm_cmd_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// watched ports
	input wire logic [CNT_W-1:0] duty_i,
	input wire logic sda_o,
	input wire logic alert_o,
	input wire logic regulate_o,
	input wire logic hs_gate_o,
	input wire logic ls_gate_o,
	input wire logic [15:0] vout_target_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic hs_q;
	logic seen_q;
	logic [15:0] since_q;
	logic [15:0] run_q;
	logic [7:0] hi_q;
	logic [7:0] lsn_q;

	// period, run time and early low-side count
	always_ff @(posedge clk_i) begin
		if (rst_i || !regulate_o) begin
			seen_q <= 1'b0;
			since_q <= 16'h0000;
			run_q <= 16'h0000;
			lsn_q <= 8'h00;
		end else begin
			seen_q <= seen_q | (hs_gate_o & ~hs_q);
			since_q <= (hs_gate_o && !hs_q) ? 16'h0001 : since_q + 16'h0001;
			run_q <= (run_q == 16'hffff) ? run_q : run_q + 16'h0001;
			lsn_q <= (ls_gate_o && run_q < 16'h00c8) ? lsn_q + 8'h01 : lsn_q;
		end
	end

	// high-side pulse width
	always_ff @(posedge clk_i) begin
		hs_q <= hs_gate_o;
		hi_q <= hs_gate_o ? hi_q + 8'h01 : 8'h00;
	end

	AST_RST_STATE: assert property (disable iff (1'b0)
		rst_i |=> !regulate_o && !hs_gate_o && !ls_gate_o && vout_target_o == 16'h0133)
		else $error("outputs not in reset state");
	AST_PERIOD: assert property ($rose(hs_gate_o) && seen_q |->
		since_q % 16'h0064 == 16'h0000)
		else $error("switching period is not 100 clocks");
	AST_WIDTH: assert property ($fell(hs_gate_o) && seen_q ##1 regulate_o |->
		$past(hi_q) == {1'b0, duty_i})
		else $error("high-side width differs from duty");
	AST_RAMP_LOW: assert property (run_q < 16'h00c8 |-> lsn_q <= 8'h04)
		else $error("low side too long at start");
	AST_COMPLEMENT: assert property (run_q > 16'h332c ##1 regulate_o |->
		$past(ls_gate_o) != $past(hs_gate_o))
		else $error("low side not full complement");
	AST_EXCLUSIVE: assert property (hs_gate_o |-> !ls_gate_o)
		else $error("both gates on");
	AST_IDLE: assert property (!regulate_o [*3] |-> !hs_gate_o && !ls_gate_o)
		else $error("gates switch while disabled");
	AST_OPEN_DRAIN: assert property (!sda_o && !alert_o)
		else $error("open-drain output drives high");
endmodule

bind power_manager_command_bank power_manager_command_bank_props chk (.clk_i(clk_i),
	.rst_i(rst_i), .duty_i(duty_i), .sda_o(sda_o), .alert_o(alert_o),
	.regulate_o(regulate_o), .hs_gate_o(hs_gate_o), .ls_gate_o(ls_gate_o),
	.vout_target_o(vout_target_o));

// [dv/pmbus_host_model.sv]
/*
 behavioural bus host: start, stop, byte transfers, write and read commands.
 assumes the bench resolves the pulled-up data line and supplies clk_i.
*/
`timescale 1ns/1ps
module pmbus_host_model
	import pm_cmd_pkg::*;
(
	// bench clock
	input wire logic clk_i,
	// bus pins
	output logic scl_o,
	output logic sda_pull_o,
	input wire logic sda_i
);
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask

	// start, also repeated start
	task automatic start();
		tick(1);
		sda_pull_o = 1'b0;
		tick(5);
		scl_o = 1'b1;
		tick(2);
		sda_pull_o = 1'b1;
		tick(4);
		scl_o = 1'b0;
	endtask

	task automatic stop();
		tick(1);
		sda_pull_o = 1'b1;
		tick(5);
		scl_o = 1'b1;
		tick(2);
		sda_pull_o = 1'b0;
		tick(4);
	endtask

	// one bit, sampled just before the falling edge
	task automatic bit_io(input logic b, output logic r);
		tick(1);
		sda_pull_o = !b;
		tick(5);
		scl_o = 1'b1;
		tick(2);
		r = sda_i;
		scl_o = 1'b0;
	endtask

	task automatic xfer(input logic [7:0] tx, input logic mb, output logic [7:0] rx);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], r);
			rx[i] = r;
		end
		bit_io(mb, r);
	endtask

	task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n);
		logic [7:0] x;
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, x);
		xfer(c, 1'b1, x);
		if (n > 0) xfer(d[7:0], 1'b1, x);
		if (n > 1) xfer(d[15:8], 1'b1, x);
		stop();
	endtask

	task automatic rd(input logic [7:0] c, input int n, output logic [15:0] d);
		logic [7:0] x;
		logic [7:0] lo;
		logic [7:0] hi;
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, x);
		xfer(c, 1'b1, x);
		start();
		xfer({DEV_ADDR, 1'b1}, 1'b1, x);
		xfer(8'hff, n < 2, lo);
		hi = 8'h00;
		if (n > 1) xfer(8'hff, 1'b1, hi);
		stop();
		d = {hi, lo};
	endtask
endmodule

// [dv/power_manager_command_bank_tb_top.sv]
/*
 bench of the command bank: defaults, read-only and guarded writes, enable
 sources, input thresholds, switching ramp, faults, store and reload.
 assumes the host model drives the bus; the data line is pulled up here.
*/
`timescale 1ns/1ps
module power_manager_command_bank_tb_top;
	import pm_cmd_pkg::*;
	logic clk_i;
	logic rst_i;
	logic scl;
	logic sda_pull;
	logic sda_oe;
	logic alert_oe;
	logic pin;
	logic [7:0] fevt;
	logic [15:0] level;
	logic [CNT_W-1:0] duty;
	logic regulate;
	logic hs;
	logic ls;
	logic [15:0] target;
	logic [15:0] rv;
	int bad_count;
	int cmp_count;
	int h;
	int l;
	wire logic sda_line;
	localparam logic [7:0] RCMD [20] = '{8'h01, 8'h02, 8'h10, 8'h19, 8'h1b, 8'h20, 8'h41,
		8'h45, 8'h47, 8'h30, 8'h21, 8'h24, 8'h27, 8'h29, 8'h2b, 8'h35, 8'h36, 8'h39, 8'h46, 8'h4a};
	localparam logic [15:0] RVAL [20] = '{16'h0000, 16'h0016, 16'h0000, 16'h00b0, 16'h0008,
		16'h0017, 16'h00bf, 16'h00bf, 16'h00ff, 16'h0000, 16'h0133, 16'h034d, 16'hd03c,
		16'hf004, 16'h00b3, 16'hf012, 16'hf010, 16'he000, 16'hf854, 16'hf84a};
	// config, pin, run, expected enable
	localparam logic [10:0] EN [9] = '{11'h0b5, 11'h0b2, 11'h0a1, 11'h0a6, 11'h0d3,
		11'h0d4, 11'h0f7, 11'h0f4, 11'h0f2};

	assign sda_line = !(sda_oe || sda_pull);

	power_manager_command_bank uut (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl),
		.sda_i(sda_line), .sda_o(), .sda_oe_o(sda_oe), .alert_o(), .alert_oe_o(alert_oe),
		.onoff_input_pin_i(pin), .fault_evt_i(fevt), .input_level_i(level), .duty_i(duty),
		.regulate_o(regulate), .hs_gate_o(hs), .ls_gate_o(ls), .vout_target_o(target));
	pmbus_host_model host (.clk_i(clk_i), .scl_o(scl), .sda_pull_o(sda_pull), .sda_i(sda_line));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rdc(input logic [7:0] c, input int n, input logic [15:0] e);
		host.rd(c, n, rv);
		check(rv, e);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask

	// gate high counts over one period
	task automatic win();
		h = 0;
		l = 0;
		repeat (100) begin
			cyc(1);
			h += int'(hs);
			l += int'(ls);
		end
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	initial begin
		#1600000;
		bad_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		end_sim();
	end

	initial begin
		rst_i = 1'b1;
		pin = 1'b1;
		fevt = 8'h00;
		level = 16'h0020;
		duty = 7'h28;
		bad_count = 0;
		cmp_count = 0;
		cyc(8);
		rst_i = 1'b0;
		cyc(4);
		for (int i = 0; i < 20; i++) begin
			rdc(RCMD[i], (i < 10) ? 1 : 2, RVAL[i]);
		end
		host.wr(CMD_FEAT, 16'h0000, 1);
		host.wr(CMD_OFMT, 16'h0000, 1);
		rdc(CMD_FEAT, 1, 16'h00b0);
		rdc(CMD_OFMT, 1, 16'h0017);
		for (int i = 0; i < 9; i++) begin
			host.wr(CMD_ONOFF, {8'h00, EN[i][10:3]}, 1);
			host.wr(CMD_RUN, {8'h00, EN[i][1], 7'h00}, 1);
			pin = EN[i][2];
			cyc(10);
			check({15'h0000, regulate}, {15'h0000, EN[i][0]});
		end
		host.wr(CMD_ONOFF, 16'h0016, 1);
		pin = 1'b1;
		level = 16'h0005;
		cyc(10);
		check({15'h0000, regulate}, 16'h0000);
		level = 16'h0011;
		cyc(10);
		check({15'h0000, regulate}, 16'h0000);
		level = 16'h0020;
		cyc(10);
		check({15'h0000, regulate}, 16'h0001);
		cyc(190);
		win();
		check(16'(h), 16'h0028);
		check({15'h0000, l < 30}, 16'h0001);
		cyc(13000);
		win();
		check(16'(h), 16'h0028);
		check(16'(l), 16'h003c);
		level = 16'h0011;
		cyc(10);
		check({15'h0000, regulate}, 16'h0001);
		host.wr(CMD_GUARD, 16'h0080, 1);
		host.wr(CMD_SETPT, 16'h0200, 2);
		rdc(CMD_SETPT, 2, 16'h0133);
		host.wr(CMD_GUARD, 16'h0000, 1);
		rdc(CMD_GUARD, 1, 16'h0000);
		host.wr(CMD_SETPT, 16'h0400, 2);
		cyc(4);
		check(target, 16'h034d);
		host.wr(CMD_SETPT, 16'h0010, 2);
		cyc(4);
		check(target, 16'h00b3);
		host.wr(CMD_FCLR, 16'h0000, 0);
		cyc(6);
		check({15'h0000, alert_oe}, 16'h0000);
		rdc(CMD_FCLR, 1, 16'h0000);
		fevt = 8'h08;
		cyc(4);
		fevt = 8'h00;
		cyc(6);
		check({15'h0000, alert_oe}, 16'h0000);
		fevt = 8'h80;
		cyc(4);
		fevt = 8'h00;
		cyc(6);
		check({15'h0000, alert_oe}, 16'h0001);
		rdc(CMD_STATUS, 1, 16'h0088);
		host.wr(CMD_FCLR, 16'h0000, 0);
		cyc(6);
		check({15'h0000, alert_oe}, 16'h0000);
		rdc(CMD_STATUS, 1, 16'h0000);
		host.wr(CMD_OVACT, 16'h0080, 1);
		rdc(CMD_OVACT, 1, 16'h0080);
		host.wr(CMD_TRIM, 16'h1234, 2);
		host.wr(CMD_SCALE, 16'hf002, 2);
		host.wr(CMD_SAVE, 16'h0000, 0);
		host.wr(CMD_TRIM, 16'h5555, 2);
		host.wr(CMD_RELOAD, 16'h0000, 0);
		rdc(CMD_TRIM, 2, 16'h1234);
		rdc(CMD_UPPER, 2, 16'h069a);
		rdc(CMD_LOWER, 2, 16'h0166);
		rdc(CMD_SCALE, 2, 16'hf002);
		host.wr(CMD_SCALE, 16'hf001, 2);
		host.wr(CMD_USAVE, 16'h0000, 0);
		host.wr(CMD_URELOAD, 16'h0000, 0);
		rdc(CMD_LOWER, 2, 16'h02cc);
		rdc(CMD_UPPER, 2, 16'h069a);
		rdc(CMD_SCALE, 2, 16'hf001);
		end_sim();
	end
endmodule
